// *** logic/lane_sat.sv ***
// Saturation of one signed element to a signed word and an unsigned byte.
`timescale 1ns/10ps
`include "lane_unit_params.svh"
module lane_sat (
	input  wire logic [31:0] din,
	output logic      [15:0] sword,
	output logic      [7:0]  ubyte
);
	logic signed [31:0] sval;
	logic signed [15:0] wval;
	assign sval = $signed(din);
	assign wval = $signed(din[15:0]);
	always_comb begin
		if (sval > 32'sd32767) begin
			sword = `LANE_SWORD_MAX;
		end else if (sval < -32'sd32768) begin
			sword = `LANE_SWORD_MIN;
		end else begin
			sword = din[15:0];
		end
	end
	// Byte saturation only looks at the low word, read as signed.
	always_comb begin
		if (wval < 16'sd0) begin
			ubyte = `LANE_UBYTE_MIN;
		end else if (wval > 16'sd255) begin
			ubyte = `LANE_UBYTE_MAX;
		end else begin
			ubyte = din[7:0];
		end
	end
endmodule

// *** logic/lane_unit_params.svh ***
// Constants for the packed lane datapath.
`ifndef LANE_UNIT_PARAMS_SVH
`define LANE_UNIT_PARAMS_SVH
`define LANE_WORD_W      16
`define LANE_DWORD_W     32
`define LANE_SHIFT_W     6
`define LANE_SEL_LO      0
`define LANE_SEL_HI      1
`define LANE_SWORD_MAX   16'h7fff
`define LANE_SWORD_MIN   16'h8000
`define LANE_UBYTE_MAX   8'hff
`define LANE_UBYTE_MIN   8'h00
`define LANE_RESULT_RST  128'h0
`endif

// *** logic/lane_unit_pkg.sv ***
// Types shared by the packed lane datapath.
package lane_unit_pkg;
	typedef enum logic [3:0] {
		op_nop       = 4'h0,
		op_pack_sdw  = 4'h1,
		op_pack_uwb  = 4'h2,
		op_unpck_lw  = 4'h3,
		op_unpck_hw  = 4'h4,
		op_unpck_ldq = 4'h5,
		op_unpck_hdq = 4'h6,
		op_extr_w    = 4'h7,
		op_insr_w    = 4'h8,
		op_mask_b    = 4'h9,
		op_and       = 4'ha,
		op_or        = 4'hb,
		op_xor       = 4'hc,
		op_shl_d     = 4'hd
	} lane_op_t;
	typedef enum logic [0:0] {
		st_idle = 1'b0,
		st_done = 1'b1
	} lane_state_t;
endpackage

// *** logic/simd_pack_unpack_lane_unit.sv ***
// Packed pack, unpack, extract, insert, mask and logic lane datapath.
`timescale 1ns/10ps
`include "lane_unit_params.svh"
module simd_pack_unpack_lane_unit (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic                   issue,
	input  wire lane_unit_pkg::lane_op_t op,
	input  wire logic                   wide,
	input  wire logic                   same_reg,
	input  wire logic [127:0]           dst_in,
	input  wire logic [127:0]           src_in,
	input  wire logic [31:0]            scalar_in,
	input  wire logic [7:0]             imm,
	output logic                        done,
	output logic                        vec_we,
	output logic                        int_we,
	output logic      [127:0]           vec_out,
	output logic      [31:0]            int_out
);
	import lane_unit_pkg::*;

	lane_state_t  state;
	logic [127:0] next_vec;
	logic [31:0]  next_int;
	logic         next_vwe;
	logic         next_iwe;
	logic [15:0]  sw_d [4];
	logic [15:0]  sw_s [4];
	logic [7:0]   ub_d [8];
	logic [7:0]   ub_s [8];
	logic [127:0] d;
	logic [127:0] s;
	logic [1:0]   wsel;
	logic [15:0]  mask;
	logic [5:0]   cnt;
	int           lanes;

	// Narrow operands only use the low 64 bits; the rest is treated as zero.
	assign d     = wide ? dst_in : {64'h0, dst_in[63:0]};
	assign s     = wide ? src_in : {64'h0, src_in[63:0]};
	assign wsel  = imm[1:0];
	assign cnt   = imm[`LANE_SHIFT_W-1:0];
	assign lanes = wide ? 4 : 2;

	// One saturator per element; dwords for word packs, words for byte packs.
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_sat
			// Only four dwords exist, so the upper slots build no dword saturator.
			if (g < 4) begin : g_dw
				lane_sat u_dw_d (
					.din   (d[g*32 +: 32]),
					.sword (sw_d[g]),
					.ubyte ()
				);
				lane_sat u_dw_s (
					.din   (s[g*32 +: 32]),
					.sword (sw_s[g]),
					.ubyte ()
				);
			end
			lane_sat u_w_d (
				.din   ({{16{d[g*16+15]}}, d[g*16 +: 16]}),
				.sword (),
				.ubyte (ub_d[g])
			);
			lane_sat u_w_s (
				.din   ({{16{s[g*16+15]}}, s[g*16 +: 16]}),
				.sword (),
				.ubyte (ub_s[g])
			);
		end
	endgenerate

	always_comb begin
		for (int i = 0; i < 16; i++) begin
			mask[i] = s[i*8+7];
		end
		if (!wide) begin
			mask[15:8] = 8'h00;
		end
	end

	always_comb begin
		next_vec = `LANE_RESULT_RST;
		next_int = 32'h0;
		next_vwe = 1'b0;
		next_iwe = 1'b0;
		case (op)
			op_pack_sdw: begin
				next_vwe = 1'b1;
				// Dest elements fill the low result words, source the high ones.
				for (int i = 0; i < 4; i++) begin
					if (i < lanes) begin
						next_vec[i*16 +: 16]         = sw_d[i];
						next_vec[(i+lanes)*16 +: 16] = sw_s[i];
					end
				end
			end
			op_pack_uwb: begin
				next_vwe = 1'b1;
				for (int i = 0; i < 8; i++) begin
					if (i < 2*lanes) begin
						next_vec[i*8 +: 8]             = ub_d[i];
						next_vec[(i+2*lanes)*8 +: 8]   = ub_s[i];
					end
				end
			end
			op_unpck_lw: begin
				next_vwe = 1'b1;
				for (int i = 0; i < 4; i++) begin
					if (i < lanes) begin
						next_vec[(2*i)*16 +: 16]   = d[i*16 +: 16];
						next_vec[(2*i+1)*16 +: 16] = s[i*16 +: 16];
					end
				end
			end
			op_unpck_hw: begin
				next_vwe = 1'b1;
				for (int i = 0; i < 4; i++) begin
					if (i < lanes) begin
						next_vec[(2*i)*16 +: 16]   = d[(i+lanes)*16 +: 16];
						next_vec[(2*i+1)*16 +: 16] = s[(i+lanes)*16 +: 16];
					end
				end
			end
			op_unpck_ldq: begin
				next_vwe = 1'b1;
				for (int i = 0; i < 2; i++) begin
					if (i < lanes/2) begin
						next_vec[(2*i)*32 +: 32]   = d[i*32 +: 32];
						next_vec[(2*i+1)*32 +: 32] = s[i*32 +: 32];
					end
				end
			end
			op_unpck_hdq: begin
				next_vwe = 1'b1;
				for (int i = 0; i < 2; i++) begin
					if (i < lanes/2) begin
						next_vec[(2*i)*32 +: 32]   = d[(i+lanes/2)*32 +: 32];
						next_vec[(2*i+1)*32 +: 32] = s[(i+lanes/2)*32 +: 32];
					end
				end
			end
			op_extr_w: begin
				next_iwe = 1'b1;
				next_int = {16'h0, s[wsel*16 +: 16]};
			end
			op_insr_w: begin
				next_vwe = 1'b1;
				next_vec = d;
				next_vec[wsel*16 +: 16] = scalar_in[15:0];
			end
			op_mask_b: begin
				next_iwe = 1'b1;
				next_int = {16'h0, mask};
			end
			op_and: begin
				next_vwe = 1'b1;
				next_vec = d & s;
			end
			op_or: begin
				next_vwe = 1'b1;
				next_vec = d | s;
			end
			op_xor: begin
				next_vwe = 1'b1;
				// A self xor must not wait on or look at the old operand value.
				next_vec = same_reg ? `LANE_RESULT_RST : (d ^ s);
			end
			op_shl_d: begin
				next_vwe = 1'b1;
				for (int i = 0; i < 4; i++) begin
					if (cnt < 6'd32) begin
						next_vec[i*32 +: 32] = d[i*32 +: 32] << cnt;
					end
				end
			end
			default: begin
				next_vwe = 1'b0;
			end
		endcase
		if (!wide) begin
			next_vec[127:64] = 64'h0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= st_idle;
		end else begin
			case (state)
				st_idle, st_done: begin
					if (issue && op != op_nop) begin
						state <= st_done;
					end else begin
						state <= st_idle;
					end
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end

	// Results are registered so the answer always lands one cycle after issue.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vec_out <= `LANE_RESULT_RST;
			int_out <= 32'h0;
			vec_we  <= 1'b0;
			int_we  <= 1'b0;
		end else if (issue) begin
			vec_out <= next_vec;
			int_out <= next_int;
			vec_we  <= next_vwe;
			int_we  <= next_iwe;
		end else begin
			vec_we  <= 1'b0;
			int_we  <= 1'b0;
		end
	end

	assign done = (state == st_done);

	// Each check looks one edge after issue, where the registered answer stands; chk_done_timing also looks one edge later.
	chk_extract_zero_ext: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_extr_w
		|=> int_out[31:16] == 16'h0 && int_we)
		else $error("extract upper half not zero");
	chk_extract_word_sel: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_extr_w && wide
		|=> int_out[15:0] == $past(src_in[imm[1:0]*16 +: 16]))
		else $error("extract picked wrong word");
	chk_word_zero_low: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_extr_w && imm[1:0] == 2'd0
		|=> int_out[15:0] == $past(src_in[15:0]))
		else $error("word zero not at low end");
	chk_insert_keep_rest: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_insr_w && wide && imm[1:0] == 2'd1
		|=> vec_out[15:0] == $past(dst_in[15:0]) && vec_out[127:32] == $past(dst_in[127:32]))
		else $error("insert disturbed other words");
	chk_insert_word_put: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_insr_w && imm[1:0] == 2'd2
		|=> vec_out[47:32] == $past(scalar_in[15:0]))
		else $error("insert word not written");
	chk_mask_narrow_clr: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_mask_b && !wide
		|=> int_out[31:8] == 24'h0 && int_out[7] == $past(src_in[63]))
		else $error("narrow mask wrong");
	chk_mask_wide_clr: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_mask_b && wide
		|=> int_out[31:16] == 16'h0 && int_out[15] == $past(src_in[127]))
		else $error("wide mask wrong");
	chk_mask_byte_order: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_mask_b
		|=> int_out[0] == $past(src_in[7]) && int_out[1] == $past(src_in[15]))
		else $error("mask bits out of byte order");
	chk_pack_sat_pos: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_pack_sdw && $signed(dst_in[31:0]) > 32'sd32767
		|=> vec_out[15:0] == 16'h7fff)
		else $error("positive word saturation wrong");
	chk_pack_sat_low: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_pack_sdw && !wide && $signed(src_in[31:0]) < -32'sd32768
		|=> vec_out[47:32] == 16'h8000)
		else $error("negative word saturation wrong");
	chk_pack_word_pass: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_pack_sdw && !wide && $signed(dst_in[31:0]) <= 32'sd32767
		&& $signed(dst_in[31:0]) >= -32'sd32768
		|=> vec_out[15:0] == $past(dst_in[15:0]))
		else $error("in range dword not packed as is");
	chk_pack_sat_neg: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_pack_uwb && dst_in[15]
		|=> vec_out[7:0] == 8'h00)
		else $error("negative byte not clamped");
	chk_pack_byte_high: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_pack_uwb && wide && !src_in[15] && src_in[15:0] > 16'h00ff
		|=> vec_out[71:64] == 8'hff)
		else $error("large word not clamped to byte maximum");
	chk_pack_signed_in: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_pack_uwb && !wide && src_in[15]
		|=> vec_out[39:32] == 8'h00)
		else $error("pack input not read as signed");
	chk_unpack_low_dq: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_unpck_ldq && !wide
		|=> vec_out[63:0] == {$past(src_in[31:0]), $past(dst_in[31:0])})
		else $error("low dword unpack wrong");
	chk_unpack_high_dq: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_unpck_hdq && !wide
		|=> vec_out[63:0] == {$past(src_in[63:32]), $past(dst_in[63:32])})
		else $error("high dword unpack wrong");
	chk_unpack_low_w: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_unpck_lw
		|=> vec_out[31:16] == $past(src_in[15:0]) && vec_out[15:0] == $past(dst_in[15:0]))
		else $error("low word unpack wrong");
	chk_unpack_high_w: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_unpck_hw && !wide
		|=> vec_out[15:0] == $past(dst_in[47:32]) && vec_out[31:16] == $past(src_in[47:32]))
		else $error("high word unpack wrong");
	chk_xor_self_zero: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_xor && same_reg
		|=> vec_out == 128'h0)
		else $error("self xor not zero");
	chk_shift_sixteen: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_shl_d && imm[5:0] == 6'd16
		|=> vec_out[31:0] == {$past(dst_in[15:0]), 16'h0})
		else $error("shift by sixteen wrong");
	chk_shift_big_clear: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_shl_d && imm[5]
		|=> vec_out == 128'h0)
		else $error("shift past dword width not zero");
	chk_or_merge: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_or && wide
		|=> vec_out == ($past(dst_in) | $past(src_in)))
		else $error("or merge wrong");
	chk_nop_no_write: assert property (@(posedge clk) disable iff (!rstn)
		issue && op == op_nop
		|=> !vec_we && !int_we && !done)
		else $error("nop raised a write");
	chk_done_timing: assert property (@(posedge clk) disable iff (!rstn)
		issue && op != op_nop
		|=> done ##1 (!done || $past(issue)))
		else $error("done not one cycle");

	cov_pack_signed: cover property (@(posedge clk) disable iff (!rstn) issue && op == op_pack_sdw);
	cov_shift_clear: cover property (@(posedge clk) disable iff (!rstn) issue && op == op_shl_d && imm[5]);
	cov_insert: cover property (@(posedge clk) disable iff (!rstn) issue && op == op_insr_w);
	cov_mask_wide: cover property (@(posedge clk) disable iff (!rstn) issue && op == op_mask_b && wide);
	cov_self_xor: cover property (@(posedge clk) disable iff (!rstn) issue && op == op_xor && same_reg);
endmodule

// *** verification/lane_issuer.sv ***
// Issuing pipeline model that presents one lane operation per call.
`timescale 1ns/10ps
module lane_issuer (
	output logic                    issue,
	output lane_unit_pkg::lane_op_t op,
	output logic                    wide,
	output logic                    same_reg,
	output logic [127:0]            dst_in,
	output logic [127:0]            src_in,
	output logic [31:0]             scalar_in,
	output logic [7:0]              imm
);
	import lane_unit_pkg::*;
	// All fields change together, so nothing moves while the unit samples them.
	task automatic put(input logic i, input lane_op_t o, input logic w, input logic s,
			input logic [127:0] d, input logic [127:0] r, input logic [31:0] c,
			input logic [7:0] m);
		issue = i;
		op = o;
		wide = w;
		same_reg = s;
		dst_in = d;
		src_in = r;
		scalar_in = c;
		imm = m;
	endtask
	initial begin
		put(1'b0, op_nop, 1'b0, 1'b0, '0, '0, '0, '0);
	end
endmodule

// *** verification/test_simd_pack_unpack_lane_unit.sv ***
// Self-checking bench for the packed lane datapath.
`timescale 1ns/10ps
module test_simd_pack_unpack_lane_unit;
	import lane_unit_pkg::*;
	logic           clk, rstn, issue, wide, same_reg, done, vec_we, int_we;
	lane_op_t       op;
	logic [127:0]   dst_in, src_in, vec_out, ev;
	logic [31:0]    scalar_in, int_out, seed, ei;
	logic [7:0]     imm;
	int             failures, checks, lastk;
	int             sh[5] = '{0, 16, 31, 32, 63};

	lane_issuer i_issuer (.issue(issue), .op(op), .wide(wide), .same_reg(same_reg),
		.dst_in(dst_in), .src_in(src_in), .scalar_in(scalar_in), .imm(imm));
	simd_pack_unpack_lane_unit i_dut (.clk(clk), .rstn(rstn), .issue(issue), .op(op),
		.wide(wide), .same_reg(same_reg), .dst_in(dst_in), .src_in(src_in),
		.scalar_in(scalar_in), .imm(imm), .done(done), .vec_we(vec_we), .int_we(int_we),
		.vec_out(vec_out), .int_out(int_out));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [127:0] rw();
		return {rnd(), rnd(), rnd(), rnd()};
	endfunction
	function automatic logic [15:0] ssat(input logic [31:0] x);
		if ($signed(x) > 32767) return 16'h7fff;
		if ($signed(x) < -32768) return 16'h8000;
		return x[15:0];
	endfunction
	function automatic logic [7:0] usat(input logic [15:0] x);
		if (x[15]) return 8'h00;
		if (x > 16'h00ff) return 8'hff;
		return x[7:0];
	endfunction
	// Returns the scalar result above the vector result.
	function automatic logic [159:0] model(input lane_op_t o, input logic w, input logic s,
			input logic [127:0] d, input logic [127:0] r, input logic [31:0] c,
			input logic [7:0] m);
		logic [127:0] v;
		logic [31:0]  i;
		int           n;
		int           j;
		v = '0;
		i = '0;
		n = w ? 4 : 2;
		case (o)
			op_pack_sdw: for (int k = 0; k < n; k++) begin
				v[16*k +: 16] = ssat(d[32*k +: 32]);
				v[16*(k+n) +: 16] = ssat(r[32*k +: 32]);
			end
			op_pack_uwb: for (int k = 0; k < 2*n; k++) begin
				v[8*k +: 8] = usat(d[16*k +: 16]);
				v[8*(k+2*n) +: 8] = usat(r[16*k +: 16]);
			end
			op_unpck_lw, op_unpck_hw: for (int k = 0; k < n; k++) begin
				j = (o == op_unpck_hw) ? k + n : k;
				v[32*k +: 32] = {r[16*j +: 16], d[16*j +: 16]};
			end
			op_unpck_ldq, op_unpck_hdq: for (int k = 0; k < n/2; k++) begin
				j = k + ((o == op_unpck_hdq) ? n/2 : 0);
				v[64*k +: 64] = {r[32*j +: 32], d[32*j +: 32]};
			end
			op_extr_w: i = {16'h0, r[16*m[1:0] +: 16]};
			op_insr_w: begin
				v = d;
				v[16*m[1:0] +: 16] = c[15:0];
			end
			op_mask_b: for (int k = 0; k < 4*n; k++) begin
				i[k] = r[8*k+7];
			end
			op_and: v = d & r;
			op_or: v = d | r;
			op_xor: v = s ? 128'h0 : d ^ r;
			op_shl_d: for (int k = 0; k < 4; k++) begin
				v[32*k +: 32] = m[5] ? 32'h0 : d[32*k +: 32] << m[4:0];
			end
			default: v = '0;
		endcase
		if (!w) v[127:64] = 64'h0;
		return {i, v};
	endfunction

	task automatic chk(input logic [159:0] g, input logic [159:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic run(input lane_op_t o, input logic w, input logic s, input logic [127:0] d,
			input logic [127:0] r, input logic [31:0] c, input logic [7:0] m);
		logic [159:0] e;
		logic         ii;
		logic         iv;
		i_issuer.put(1'b1, o, w, s, d, r, c, m);
		@(posedge clk);
		#1;
		e = model(o, w, s, d, r, c, m);
		ii = (o == op_extr_w) || (o == op_mask_b);
		iv = (o != op_nop) && (o <= op_shl_d) && !ii;
		chk({vec_we, int_we}, {iv, ii});
		if (o <= op_shl_d) chk(done, o != op_nop);
		if (iv) chk(vec_out, e[127:0]);
		if (ii) chk(int_out, e[159:128]);
		if (!iv && !ii) chk({int_out, vec_out}, 160'h0);
		lastk = iv ? 1 : (ii ? 2 : 0);
		ev = e[127:0];
		ei = e[159:128];
	endtask
	// A quiet cycle: pulses must drop and results must hold.
	task automatic idle();
		i_issuer.put(1'b0, op_nop, 1'b0, 1'b0, rw(), rw(), rnd(), 8'(rnd()));
		@(posedge clk);
		#1;
		chk({done, vec_we, int_we}, 3'h0);
		if (lastk == 1) chk(vec_out, ev);
		if (lastk == 2) chk(int_out, ei);
	endtask
	task automatic complete_run();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#400000;
		failures++;
		complete_run();
	end
	initial begin
		logic [127:0] d;
		failures = 0;
		checks = 0;
		lastk = 0;
		seed = 32'hc6a6;
		rstn = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk({done, vec_we, int_we}, 3'h0);
		chk({int_out, vec_out}, 160'h0);
		rstn = 1'b1;
		run(op_pack_sdw, '0, '0, 128'h8000_00007fff, 128'h80000000_ffff8000, 0, 0);
		run(op_pack_sdw, 1'b1, 1'b0, rw(), rw(), 0, 0);
		run(op_pack_uwb, '0, '0, 64'h8000_ffff_0100_00ff, 64'h7fff_0080_ff00_0001, 0, 0);
		run(op_pack_uwb, 1'b1, 1'b0, rw(), rw(), 0, 0);
		for (int k = 3; k < 7; k++) begin
			run(lane_op_t'(k), 1'b0, 1'b0, rw(), rw(), 0, 0);
			run(lane_op_t'(k), 1'b1, 1'b0, rw(), rw(), 0, 0);
		end
		for (int k = 0; k < 4; k++) begin
			run(op_extr_w, 1'b0, 1'b0, rw(), rw(), rnd(), 8'(k) | 8'hfc);
			run(op_insr_w, k[0], 1'b0, rw(), rw(), rnd(), 8'(k) | 8'hfc);
		end
		run(op_mask_b, '0, '0, rw(), {64'hffffffff_ffffffff, 64'h807fff00_01800081}, 0, 0);
		run(op_mask_b, 1'b1, 1'b0, rw(), rw(), 0, 0);
		foreach (sh[k]) run(op_shl_d, 1'b1, 1'b0, rw(), rw(), 0, 8'(sh[k]));
		run(op_or, 1'b0, 1'b0, 128'hffff0000_ffff0000, 128'h0000ffff_0000ffff, 0, 0);
		run(op_and, 1'b1, 1'b0, rw(), rw(), 0, 0);
		d = rw();
		run(op_xor, 1'b1, 1'b1, d, d, 0, 0);
		// Unknown operands show that a self xor never looks at the old value.
		run(op_xor, 1'b1, 1'b1, {128{1'bx}}, {128{1'bx}}, 0, 0);
		run(op_xor, 1'b1, 1'b0, rw(), rw(), 0, 0);
		run(op_nop, 1'b1, 1'b0, rw(), rw(), 0, 0);
		run(lane_op_t'(4'he), 1'b1, 1'b0, rw(), rw(), 0, 0);
		idle();
		repeat (400) begin
			d = rw();
			run(lane_op_t'(4'(rnd() % 14)), rnd() > 32'h7fffffff, 1'b0, d, rw(), rnd(), 8'(rnd()));
			if (rnd() % 4 == 0) idle();
		end
		complete_run();
	end
endmodule
